// ==== bbc_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - bit toggle inverts one selected bit, others kept, no flags touched
// - bit toggle opcode: nibble 0111, bit index, access flag, address
// - access flag zero picks access bank; one uses bank select register
// - branch on overflow taken only when overflow flag is one
// - branch on overflow upper byte is 1110 0100, low byte offset
// - branch on zero taken only when zero flag is one
// - branch on zero upper byte is 1110 0000, low byte offset
// - taken target is incremented pc plus twice signed offset
// - untaken branch one cycle; taken writes pc in Q4 then nop cycle
// - call pushes address four bytes past the call onto return stack
// - fast call copies work, status and bank select into shadows
// - non fast call leaves shadow registers unchanged
// - call loads twenty bit literal into pc bits 20 to 1
// - call is two words: 1110110s with k7:0, then 1111 with k19:8
// - call pushes in Q3, loads pc in Q4, then a nop cycle
// - register clear writes zero and sets zero flag in one cycle
// - register clear opcode is 0110101a with eight bit address
module bbc_exec
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [bbc_pkg::IW_W-1:0] instrWord,
  input wire logic [bbc_pkg::IW_W-1:0] nextWord,
  input wire logic overflowFlag,
  input wire logic zeroFlag,
  input wire logic [bbc_pkg::BANK_W-1:0] bankSelectReg,
  input wire logic [bbc_pkg::DW-1:0] workReg,
  input wire logic [bbc_pkg::DW-1:0] statusReg,
  input wire logic [bbc_pkg::DW-1:0] memRdData,
  output logic [bbc_pkg::PC_W-1:0] pcOut,
  output logic [3:0] phaseOut,
  output logic nopCycle,
  output logic [bbc_pkg::DA_W-1:0] memAddr,
  output logic memRdEn,
  output logic memWrEn,
  output logic [bbc_pkg::DW-1:0] memWrData,
  output logic zeroSet,
  output logic pushEn,
  output logic [bbc_pkg::PC_W-1:0] pushData,
  output logic [bbc_pkg::DW-1:0] workShadowReg,
  output logic [bbc_pkg::DW-1:0] flagsShadowReg,
  output logic [bbc_pkg::BANK_W-1:0] bankShadowReg
);
  import bbc_pkg::*;

  bbc_phase_t phase_q;
  logic [PC_W-1:0] pc_q;
  logic [IW_W-1:0] instr_q;
  logic [IW_W-1:0] ext_q;
  logic exec_q;
  logic nop_q;
  logic [DA_W-1:0] addr_q;
  logic [DW-1:0] rdData_q;
  logic [DW-1:0] wrData_q;
  logic [PC_W-1:0] ret_q;
  logic [DW-1:0] wsh_q;
  logic [DW-1:0] ssh_q;
  logic [BANK_W-1:0] bsh_q;
  logic isToggle, isBrOvf, isBrZero, isCall, isClear, taken, flowChange;
  logic [2:0] bitIdx;
  logic [DW-1:0] bitMask;
  logic [PC_W-1:0] branchTarget;
  logic [PC_W-1:0] callTarget;
  logic [BANK_W-1:0] bankSel;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the latched instruction
  always_comb begin
    isToggle = instr_q[OPC_MSB:NIB_LSB] == OP_TOGGLE_NIB;
    isBrOvf = instr_q[OPC_MSB:HI_LSB] == OP_BR_OVF_HI;
    isBrZero = instr_q[OPC_MSB:HI_LSB] == OP_BR_ZERO_HI;
    isCall = instr_q[OPC_MSB:HI7_LSB] == OP_CALL_HI7;
    isClear = instr_q[OPC_MSB:HI7_LSB] == OP_CLEAR_HI7;
    bitIdx = instr_q[BIT_IDX_LSB+BIT_IDX_W-1:BIT_IDX_LSB];
    bitMask = ONE_BIT << bitIdx;
    // branch condition per opcode
    taken = (isBrOvf && overflowFlag) || (isBrZero && zeroFlag);
    flowChange = taken || isCall;
    // pc plus one step points past the branch, offset doubled
    branchTarget = pc_q + PC_STEP
      + {{OFS_EXT_W{instr_q[LIT_MSB]}}, instr_q[LIT_MSB:0], 1'b0};
    // second word carries k19:8, first word k7:0
    callTarget = {ext_q[EXT_MSB:0], instr_q[LIT_MSB:0], 1'b0};
  end

  // bank for the incoming instruction's register address
  always_comb begin
    if (instrWord[ACC_BIT]) begin
      bankSel = bankSelectReg;
    end else if (instrWord[ACC_SPLIT_BIT]) begin
      bankSel = ACC_HI_BANK;
    end else begin
      bankSel = ACC_LO_BANK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // four phase sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= PH_Q1;
    end else begin
      unique case (phase_q)
        PH_Q1: phase_q <= PH_Q2;
        PH_Q2: phase_q <= PH_Q3;
        PH_Q3: phase_q <= PH_Q4;
        PH_Q4: phase_q <= PH_Q1;
      endcase
    end
  end

  // decode phase: latch words, address and return address
  always_ff @(posedge clk) begin
    if (rst) begin
      instr_q <= '0;
      ext_q <= '0;
      exec_q <= 1'b0;
      addr_q <= '0;
      ret_q <= PC_RESET;
    end else if (phase_q == PH_Q1) begin
      instr_q <= instrWord;
      ext_q <= nextWord;
      exec_q <= !nop_q; // flushed cycle does nothing
      addr_q <= {bankSel, instrWord[LIT_MSB:0]};
      ret_q <= pc_q + CALL_RET_STEP;
    end
  end

  // nop after a taken branch or a call
  always_ff @(posedge clk) begin
    if (rst) begin
      nop_q <= 1'b0;
    end else if (phase_q == PH_Q4) begin
      nop_q <= exec_q && flowChange;
    end
  end

  // read register in Q2
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_q <= '0;
    end else if (phase_q == PH_Q2) begin
      rdData_q <= memRdData;
    end
  end

  // process data in Q3
  always_ff @(posedge clk) begin
    if (rst) begin
      wrData_q <= '0;
    end else if (phase_q == PH_Q3) begin
      if (isClear) begin
        wrData_q <= CLR_VALUE;
      end else begin
        wrData_q <= rdData_q ^ bitMask;
      end
    end
  end

  // shadow save on fast call, in Q3
  always_ff @(posedge clk) begin
    if (rst) begin
      wsh_q <= '0;
      ssh_q <= '0;
      bsh_q <= '0;
    end else if (phase_q == PH_Q3 && exec_q && isCall
                 && instr_q[FAST_BIT]) begin
      wsh_q <= workReg;
      ssh_q <= statusReg;
      bsh_q <= bankSelectReg;
    end
  end

  // program counter written in Q4
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= PC_RESET;
    end else if (phase_q == PH_Q4 && exec_q) begin
      if (isCall) begin
        pc_q <= callTarget;
      end else if (taken) begin
        pc_q <= branchTarget;
      end else begin
        pc_q <= pc_q + PC_STEP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign pcOut = pc_q;
  assign phaseOut = phase_q;
  assign nopCycle = !exec_q;
  assign memAddr = addr_q;
  assign memRdEn = phase_q == PH_Q2 && exec_q && (isToggle || isClear);
  assign memWrEn = phase_q == PH_Q4 && exec_q && (isToggle || isClear);
  assign memWrData = wrData_q;
  assign zeroSet = phase_q == PH_Q4 && exec_q && isClear;
  assign pushEn = phase_q == PH_Q3 && exec_q && isCall;
  assign pushData = ret_q;
  assign workShadowReg = wsh_q;
  assign flagsShadowReg = ssh_q;
  assign bankShadowReg = bsh_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_toggle_data: assert property (@(posedge clk) disable iff (rst)
    (memWrEn && isToggle) |-> ((memWrData ^ rdData_q)
      == (ONE_BIT << instr_q[BIT_IDX_LSB +: BIT_IDX_W])) && !zeroSet)
    else $error("toggle result wrong");

  a_clear_zero: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && isClear)
    |-> (memWrEn && zeroSet && memWrData == CLR_VALUE))
    else $error("clear did not write zero");

  a_access_bank: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q2 && !instr_q[ACC_BIT])
    |-> (addr_q[DA_W-1:DW] == (instr_q[ACC_SPLIT_BIT] ? ACC_HI_BANK
         : ACC_LO_BANK)))
    else $error("access bank not selected");

  a_branch_taken: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && taken && !isCall)
    |=> (pc_q == $past(branchTarget) && nop_q) ##1 nop_q [*3]
        ##1 (!nop_q && !exec_q))
    else $error("taken branch target or nop wrong");

  a_branch_skip: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && (isBrOvf || isBrZero) && !taken)
    |=> (pc_q == $past(pc_q) + PC_STEP) && !nop_q)
    else $error("untaken branch not sequential");

  a_nop_stall: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q1 && nop_q)
    |=> (!exec_q && !memWrEn && !pushEn) [*4] ##0 $stable(pc_q))
    else $error("nop cycle not idle");

  a_call_push: assert property (@(posedge clk) disable iff (rst)
    pushEn |-> (pushData == pc_q + CALL_RET_STEP) && phase_q == PH_Q3)
    else $error("call push address wrong");

  a_call_load: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && isCall)
    |=> (pc_q == {$past(ext_q[EXT_MSB:0]), $past(instr_q[LIT_MSB:0]),
        1'b0}) && nop_q)
    else $error("call target wrong");

  a_shadow_copy: assert property (@(posedge clk) disable iff (rst)
    (pushEn && instr_q[FAST_BIT])
    |=> (workShadowReg == $past(workReg)
         && flagsShadowReg == $past(statusReg)
         && bankShadowReg == $past(bankSelectReg)))
    else $error("fast call shadow not saved");

  a_shadow_hold: assert property (@(posedge clk) disable iff (rst)
    (pushEn && !instr_q[FAST_BIT])
    |=> $stable(workShadowReg) && $stable(flagsShadowReg)
        && $stable(bankShadowReg))
    else $error("shadow changed on plain call");

  a_seq_step: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && !flowChange)
    |=> pc_q == $past(pc_q) + PC_STEP)
    else $error("pc did not advance by two");

  // untaken branch must not flush the following cycle
  a_branch_single: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && (isBrOvf || isBrZero) && !taken)
    |=> ##1 !nopCycle)
    else $error("untaken branch flushed a cycle");

  a_ovf_taken: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && isBrOvf && overflowFlag)
    |=> nop_q && pc_q == $past(branchTarget))
    else $error("overflow branch not taken");

  a_ovf_held: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && isBrOvf && !overflowFlag)
    |=> !nop_q)
    else $error("overflow branch taken with flag clear");

  a_zero_taken: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && isBrZero && zeroFlag)
    |=> nop_q && pc_q == $past(branchTarget))
    else $error("zero branch not taken");

  a_zero_held: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && exec_q && isBrZero && !zeroFlag)
    |=> !nop_q && pc_q == $past(pc_q) + PC_STEP)
    else $error("zero branch taken with flag clear");

  a_clear_read: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q2 && exec_q && isClear)
    |-> memRdEn && memAddr[DW-1:0] == instr_q[LIT_MSB:0])
    else $error("clear register address wrong");

  // a write closes the same cycle whose Q2 read it
  a_write_slot: assert property (@(posedge clk) disable iff (rst)
    memWrEn |-> phase_q == PH_Q4 && $past(memRdEn, 2))
    else $error("write strobe outside its cycle");

  a_push_single: assert property (@(posedge clk) disable iff (rst)
    pushEn |=> (!pushEn) [*7])
    else $error("second push too soon after call");

endmodule : bbc_exec
`default_nettype wire

// ==== bbc_pkg.sv ====
`default_nettype none
package bbc_pkg;
  // widths
  localparam int PC_W = 21;
  localparam int IW_W = 16;
  localparam int DA_W = 12;
  localparam int BANK_W = 4;
  localparam int DW = 8;
  // opcode fields and values
  localparam logic [3:0] OP_TOGGLE_NIB = 4'h7;
  localparam logic [7:0] OP_BR_OVF_HI = 8'hE4;
  localparam logic [7:0] OP_BR_ZERO_HI = 8'hE0;
  localparam logic [6:0] OP_CALL_HI7 = 7'h76;
  localparam logic [6:0] OP_CLEAR_HI7 = 7'h35;
  localparam logic [3:0] OP_CALL2_NIB = 4'hF;
  localparam int BIT_IDX_LSB = 9;
  localparam int ACC_BIT = 8;
  localparam int FAST_BIT = 8;
  localparam int ACC_SPLIT_BIT = 7;
  // instruction word field positions
  localparam int OPC_MSB = 15;
  localparam int NIB_LSB = 12;
  localparam int HI_LSB = 8;
  localparam int HI7_LSB = 9;
  localparam int LIT_MSB = 7;
  localparam int EXT_MSB = 11;
  localparam int OFS_EXT_W = 12;
  localparam int BIT_IDX_W = 3;
  // access bank halves and program counter steps
  localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] CALL_RET_STEP = 21'h000004;
  localparam logic [DW-1:0] CLR_VALUE = 8'h00;
  localparam logic [DW-1:0] ONE_BIT = 8'h01;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  // four phases of one instruction cycle
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } bbc_phase_t;
endpackage : bbc_pkg
`default_nettype wire

// ==== test_bbc_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_bbc_exec;
  import bbc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instrWord = 16'h0000;
  logic [15:0] nextWord = 16'h0000;
  logic overflowFlag = 1'b0;
  logic zeroFlag = 1'b0;
  logic [3:0] bankSelectReg = 4'h5;
  logic [7:0] workReg = 8'h00;
  logic [7:0] statusReg = 8'h00;
  logic [7:0] memRdData = 8'h00;
  logic [20:0] pcOut, pushData, pc0, sPc, sPData, expPc;
  logic [3:0] phaseOut, bankShadowReg;
  logic [11:0] memAddr, sAddr;
  logic [7:0] memWrData, sWData, op, n, workShadowReg, flagsShadowReg;
  logic nopCycle, memRdEn, memWrEn, zeroSet, pushEn;
  logic sNop, sRd, sWr, sZ, sPush, tk;
  int mismatches = 0;
  int checkCount = 0;
  int cycles = 0;

  bbc_exec dut (.clk(clk), .rst(rst), .instrWord(instrWord),
    .nextWord(nextWord), .overflowFlag(overflowFlag), .zeroFlag(zeroFlag),
    .bankSelectReg(bankSelectReg), .workReg(workReg),
    .statusReg(statusReg), .memRdData(memRdData), .pcOut(pcOut),
    .phaseOut(phaseOut), .nopCycle(nopCycle), .memAddr(memAddr),
    .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData),
    .zeroSet(zeroSet), .pushEn(pushEn), .pushData(pushData),
    .workShadowReg(workShadowReg), .flagsShadowReg(flagsShadowReg),
    .bankShadowReg(bankShadowReg));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      endSim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare, report and one instruction cycle sampled phase by phase
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      mismatches++;
    end
  endtask : check

  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : endSim

  task automatic exec(input logic [15:0] iw, input logic [15:0] nw,
                      input logic [7:0] rd);
    while (phaseOut !== PH_Q1) @(negedge clk);
    pc0 = pcOut;
    instrWord = iw;
    nextWord = nw;
    memRdData = rd;
    @(negedge clk);
    sNop = nopCycle;
    sRd = memRdEn;
    sAddr = memAddr;
    @(negedge clk);
    sPush = pushEn;
    sPData = pushData;
    @(negedge clk);
    sWr = memWrEn;
    sWData = memWrData;
    sZ = zeroSet;
    @(negedge clk);
    sPc = pcOut;
  endtask : exec

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check({phaseOut, nopCycle, pcOut}, {4'h1, 1'b1, 21'h000000});
    // toggle each bit through the bank select register
    for (int b = 0; b < 8; b++) begin
      exec({OP_TOGGLE_NIB, b[2:0], 1'b1, 8'h33}, 16'h0000, 8'hA5);
      check(sWData, 8'hA5 ^ (ONE_BIT << b));
      check({sRd, sWr, sZ, sPush, sAddr}, {4'b1100, 4'h5, 8'h33});
      check(sPc, pc0 + 21'h2);
    end
    // access bank, low and high halves
    exec(16'h7825, 16'h0000, 8'h75);
    check({sAddr, sWData}, {12'h025, 8'h65});
    exec(16'h7090, 16'h0000, 8'h00);
    check({sAddr, sWData}, {12'hF90, 8'h01});
    // register clear with both access flag values
    for (int a = 0; a < 2; a++) begin
      exec({OP_CLEAR_HI7, a[0], 8'h44}, 16'h0000, 8'h5A);
      check({sWr, sZ, sWData}, {2'b11, 8'h00});
      check(sAddr, a ? 12'h544 : 12'h044);
    end
    // both branches, each flag, extreme offsets, then a following clear
    for (int i = 0; i < 8; i++) begin
      op = i[0] ? OP_BR_OVF_HI : OP_BR_ZERO_HI;
      n = i[1] ? 8'h80 : 8'h7F;
      overflowFlag = i[1];
      zeroFlag = i[2];
      tk = i[0] ? i[1] : i[2];
      exec({op, n}, 16'h0000, 8'h00);
      expPc = pc0 + 21'h2 + (tk ? {{12{n[7]}}, n, 1'b0} : 21'h0);
      check(sPc, expPc);
      exec(16'h6A10, 16'h0000, 8'h11);
      check({sNop, sWr}, {tk, ~tk});
      check(sPc, pc0 + (tk ? 21'h0 : 21'h2));
    end
    // fast call saves shadows, then a flushed cycle
    workReg = 8'h3C;
    statusReg = 8'h1F;
    bankSelectReg = 4'hA;
    exec({OP_CALL_HI7, 1'b1, 8'hCD}, {OP_CALL2_NIB, 12'hAB9}, 8'h00);
    check({sPush, sPData}, {1'b1, pc0 + 21'h4});
    check(sPc, {20'hAB9CD, 1'b0});
    check({workShadowReg, flagsShadowReg, bankShadowReg},
          {8'h3C, 8'h1F, 4'hA});
    exec(16'h6A10, 16'h0000, 8'h11);
    check({sNop, sWr, sPc}, {2'b10, 20'hAB9CD, 1'b0});
    // plain call keeps shadows
    workReg = 8'h99;
    statusReg = 8'h01;
    bankSelectReg = 4'h2;
    exec({OP_CALL_HI7, 1'b0, 8'h10}, {OP_CALL2_NIB, 12'h001}, 8'h00);
    check({sPush, sPData}, {1'b1, pc0 + 21'h4});
    check(sPc, {20'h00110, 1'b0});
    check({workShadowReg, flagsShadowReg, bankShadowReg},
          {8'h3C, 8'h1F, 4'hA});
    exec(16'h0000, 16'h0000, 8'h00);
    check(sPc, pc0);
    exec(16'h0000, 16'h0000, 8'h00);
    check(sPc, pc0 + 21'h2);
    endSim();
  end
endmodule : test_bbc_exec
`default_nettype wire
